// ---- include/srocp_pkg.sv ----
// package for the serial relay output control block
// assumes: one system clock domain plus the host serial clock domain
package srocp_pkg;
    localparam int WORD_BITS = 8;
    localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h00;
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
    localparam int FIRST_OUTPUT_IDX = 0;
    localparam int SYS_CLK_MHZ = 25;
    // supervisor delay before the reset pin is released, in microseconds
    localparam int RESET_DELAY_US = 6000;
    localparam int RESET_DELAY_CYCLES = RESET_DELAY_US * SYS_CLK_MHZ;
    localparam logic [17:0] RESET_COUNT_ZERO = 18'h00000;

    typedef struct packed {
        logic [7:0] word;
        logic toggle;
    } srocp_word_s;

    typedef enum logic [1:0] {
        SROCP_HOLD = 2'b00,
        SROCP_DELAY = 2'b01,
        SROCP_RUN = 2'b11
    } srocp_por_e;
endpackage

// ---- design/srocp_shift.sv ----
// serial receive half: shifts bits on the host serial clock
// assumes: serial clock low while the frame select is high
`timescale 1ns/10ps
module srocp_shift (
    input wire logic serial_clk,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    input wire logic link_rst_n,
    output srocp_pkg::srocp_word_s word_out
);
    logic [7:0] shift_reg;
    logic [3:0] bit_count;
    logic toggle;
    logic [7:0] word_reg;

    // shift on rising serial clock, msb first
    always_ff @(posedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_reg <= srocp_pkg::OUTPUT_CONTROL_RESET;
        end else if (!frame_select_n) begin
            shift_reg <= {shift_reg[6:0], serial_data_in};
        end
    end

    // bit counter, restarted by the frame select edge
    always_ff @(posedge serial_clk or posedge frame_select_n) begin
        if (frame_select_n) begin
            bit_count <= srocp_pkg::BIT_COUNT_ZERO;
        end else if (!(&bit_count)) begin // saturate well above eight
            bit_count <= bit_count + 4'h1;
        end
    end

    // frame end: capture the word when exactly eight bits arrived
    always_ff @(posedge frame_select_n or negedge link_rst_n) begin
        if (!link_rst_n) begin
            word_reg <= srocp_pkg::OUTPUT_CONTROL_RESET;
            toggle <= 1'b0;
        end else if (bit_count == srocp_pkg::BIT_COUNT_FULL) begin
            word_reg <= shift_reg;
            toggle <= ~toggle;
        end
    end

    // one driver for the whole carrier
    assign word_out = '{word: word_reg, toggle: toggle};
endmodule

// ---- design/srocp_top.sv ----
// Summary of operation
// - eight-bit words on host serial clock
// - one eight-bit register, resets to zero
// - bit one means on, msb is eight
// - force pin low: output one follows bit
// - force pin high: output one on
// - brown-out drives flag low, outputs off
// - recovery restores stored outputs, no rewrite
// - reset forces outputs off, clears register
// - reset held until supply good and delay
// - word latched when frame select rises
//
// top of the relay output control: register, overrides, reset supervisor
// assumes: brown-out and supply-good come from analog comparators
`timescale 1ns/10ps
module srocp_top #(
    parameter int RESET_DELAY = srocp_pkg::RESET_DELAY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    input wire logic first_output_force_on,
    input wire logic brownout_sense_input,
    input wire logic supply_good,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic brownout_flag_n,
    output logic [7:0] driver_outputs
);
    srocp_pkg::srocp_word_s link_word;
    srocp_pkg::srocp_por_e por_state;
    logic [17:0] delay_count;
    logic [7:0] output_control;
    logic [2:0] toggle_sync;
    logic [1:0] force_sync;
    logic [1:0] brown_sync;
    logic [1:0] good_sync;
    logic [1:0] pin_sync;
    logic [1:0] pin_rst_sync;
    logic chip_rst_n;
    logic outputs_enabled;
    wire logic [7:0] next_outputs;

    // serial receive side on the host clock
    srocp_shift u_shift (
        .serial_clk(serial_clk),
        .frame_select_n(frame_select_n),
        .serial_data_in(serial_data_in),
        .link_rst_n(chip_rst_n),
        .word_out(link_word)
    );

    // frame toggle from the link domain, two stages and an edge stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_sync <= 3'h0;
        end else begin
            toggle_sync <= {toggle_sync[1:0], link_word.toggle};
        end
    end

    // force pin synchroniser, idle low like an open pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            force_sync <= 2'h0;
        end else begin
            force_sync <= {force_sync[0], first_output_force_on};
        end
    end

    // brown-out comparator synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            brown_sync <= 2'h0;
        end else begin
            brown_sync <= {brown_sync[0], brownout_sense_input};
        end
    end

    // supply-good comparator synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            good_sync <= 2'h0;
        end else begin
            good_sync <= {good_sync[0], supply_good};
        end
    end

    // reset wire synchroniser, sees our own pull and outside pulls
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], reset_pin_in};
        end
    end

    // supervisor: hold reset pin low until supply good and delay done
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_state <= srocp_pkg::SROCP_HOLD;
        end else if (!good_sync[1]) begin
            por_state <= srocp_pkg::SROCP_HOLD;
        end else begin
            unique case (por_state)
                srocp_pkg::SROCP_HOLD: begin
                    por_state <= srocp_pkg::SROCP_DELAY;
                end
                srocp_pkg::SROCP_DELAY: begin
                    if (delay_count >= 18'(RESET_DELAY - 1)) begin
                        por_state <= srocp_pkg::SROCP_RUN;
                    end
                end
                srocp_pkg::SROCP_RUN: begin
                    por_state <= srocp_pkg::SROCP_RUN;
                end
                default: begin
                    por_state <= srocp_pkg::SROCP_HOLD;
                end
            endcase
        end
    end

    // release delay counter, cleared outside the delay state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_count <= srocp_pkg::RESET_COUNT_ZERO;
        end else if (!good_sync[1] ||
                (por_state != srocp_pkg::SROCP_DELAY)) begin
            delay_count <= srocp_pkg::RESET_COUNT_ZERO;
        end else if (delay_count < 18'(RESET_DELAY - 1)) begin
            delay_count <= delay_count + 18'h00001;
        end
    end

    // open-drain reset pin: drive low unless running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b1;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= (por_state != srocp_pkg::SROCP_RUN);
        end
    end

    // internal reset: pin low (ours or external) resets the logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_rst_sync <= 2'h0;
        end else begin
            pin_rst_sync <= {pin_rst_sync[0],
                pin_sync[1] && (por_state == srocp_pkg::SROCP_RUN)};
        end
    end
    assign chip_rst_n = rst_n & pin_rst_sync[1];

    // output control register, loaded on each completed eight-bit frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_control <= srocp_pkg::OUTPUT_CONTROL_RESET;
        end else if (!pin_rst_sync[1]) begin
            output_control <= srocp_pkg::OUTPUT_CONTROL_RESET;
        end else if (toggle_sync[2] != toggle_sync[1]) begin
            output_control <= link_word.word;
        end
    end

    // outputs allowed only with supply ok and internal reset released
    assign outputs_enabled = brown_sync[1] && pin_rst_sync[1];

    // per-output gating; output one also obeys the force pin
    for (genvar g = 0; g < srocp_pkg::WORD_BITS; g++) begin : g_gate
        if (g == srocp_pkg::FIRST_OUTPUT_IDX) begin : g_first
            assign next_outputs[g] = outputs_enabled &&
                (output_control[g] || force_sync[1]);
        end else begin : g_rest
            assign next_outputs[g] = outputs_enabled &&
                output_control[g];
        end
    end

    // registered driver outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            driver_outputs <= srocp_pkg::OUTPUT_CONTROL_RESET;
        end else begin
            driver_outputs <= next_outputs;
        end
    end

    // brown-out flag, low while the comparator reports low supply
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_flag_n <= 1'b0;
        end else begin
            brownout_flag_n <= brown_sync[1];
        end
    end
endmodule

// ---- tb/srocp_assertions.sv ----
// checker for the relay output top, watching its ports only
// assumes: bound to srocp_top, all checks on sys_clk
`timescale 1ns/10ps
module srocp_assertions #(
    parameter int RESET_DELAY = 20
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic frame_select_n,
    input wire logic first_output_force_on,
    input wire logic brownout_sense_input,
    input wire logic supply_good,
    input wire logic reset_pin_in,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic brownout_flag_n,
    input wire logic [7:0] driver_outputs
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] good_cnt;
    // cycles with supply good, saturating at the delay
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            good_cnt <= 32'h0;
        else if (!supply_good)
            good_cnt <= 32'h0;
        else if (good_cnt < 32'(RESET_DELAY))
            good_cnt <= good_cnt + 32'h1;
    end
    property p_rst_off; !reset_pin_in [*6] |-> driver_outputs == 8'h00;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("on in reset");
    property p_pin_low; reset_pin_oe |-> reset_pin_out == 1'b0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin high");
    property p_wait; $fell(reset_pin_oe) |-> good_cnt >= 32'(RESET_DELAY);
    endproperty
    a_wait: assert property (p_wait) else $error("early release");
    property p_release; $rose(supply_good) |-> ##[1:40] !reset_pin_oe;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_bo_off; !brownout_sense_input [*5] |->
        !brownout_flag_n && driver_outputs == 8'h00; endproperty
    a_bo_off: assert property (p_bo_off) else $error("brown-out");
    property p_bo_flag; $rose(brownout_flag_n) |->
        $past(brownout_sense_input, 3); endproperty
    a_bo_flag: assert property (p_bo_flag) else $error("flag rise");
    property p_force; (first_output_force_on && brownout_sense_input &&
        reset_pin_in) [*6] |-> driver_outputs[0]; endproperty
    a_force: assert property (p_force) else $error("force off");
    property p_hold; (frame_select_n && brownout_sense_input && reset_pin_in
        && !first_output_force_on) [*8] |=> $stable(driver_outputs);
    endproperty
    a_hold: assert property (p_hold) else $error("stray change");
endmodule

// ---- tb/srocp_host.sv ----
// host model driving the serial link of the relay block
// assumes: caller waits for the reset wire to rise first
`timescale 1ns/10ps
module srocp_host (
    output logic serial_clk,
    output logic frame_select_n,
    output logic serial_data_in
);
    // idle: clock low, select high
    initial begin
        serial_clk = 1'b0;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // one frame of n bits, msb first, 15 ns link period
    task automatic send(input logic [7:0] w, input int n);
        frame_select_n = 1'b0;
        #10;
        for (int i = 7; i > 7 - n; i--) begin
            serial_data_in = w[(i + 8) % 8]; // long frames wrap
            #7.5 serial_clk = 1'b1;
            #7.5 serial_clk = 1'b0;
        end
        #10 frame_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #400;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// top bench: host model, random and corner frames, verdict
// assumes: design, checker and host compiled before this file
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n, force_on, sense, good, ext_low, sclk, cs_n, sdi;
    logic pin_out, pin_oe, flag_n;
    logic [7:0] outs, w;
    logic [31:0] seed = 32'h000032F2;
    int fails = 0;
    int total_checks = 0;
    // open-drain reset wire with pull-up
    wire pin_in = (pin_oe ? pin_out : 1'b1) & !ext_low;
    always #20 sys_clk = ~sys_clk;
    srocp_host host (.serial_clk(sclk), .frame_select_n(cs_n),
        .serial_data_in(sdi));
    srocp_top #(.RESET_DELAY(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .serial_clk(sclk), .frame_select_n(cs_n), .serial_data_in(sdi),
        .first_output_force_on(force_on), .brownout_sense_input(sense),
        .supply_good(good), .reset_pin_in(pin_in), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .brownout_flag_n(flag_n),
        .driver_outputs(outs));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // expected outputs from stored word, force pin and supply state
    function automatic logic [7:0] exp_out(input logic [7:0] word,
        input logic force_pin, input logic sense_ok);
        logic [7:0] e;
        e = word;
        e[0] = word[0] | force_pin;
        return sense_ok ? e : 8'h00;
    endfunction
    // bounded wait for the reset wire to rise, then settle
    task automatic wait_release;
        for (int i = 0; i < 100 && !pin_in; i++) cyc(1);
        if (!pin_in) fails++;
        cyc(6);
    endtask
    task automatic final_report;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset, release, then frames, force, brown-out, external reset
    initial begin
        {rst_n, force_on, ext_low, good} = 4'h0;
        sense = 1'b1;
        cyc(20);
        rst_n = 1'b1;
        chk(8'h00, outs);
        chk(8'h01, {7'h00, pin_oe});
        good = 1'b1;
        wait_release;
        if (fails == 0) begin
            for (int i = 0; i < 6; i++) begin
                seed = xs(seed);
                w = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : seed[7:0];
                host.send(w, 8);
                cyc(8);
                chk(exp_out(w, 1'b0, 1'b1), outs);
                // frame start to frame start is 2499 cycles
                cyc(2478);
            end
            host.send(~w, 7);
            cyc(8);
            chk(exp_out(w, 1'b0, 1'b1), outs);
            host.send(~w, 9);
            cyc(8);
            chk(exp_out(w, 1'b0, 1'b1), outs);
            force_on = 1'b1;
            host.send(8'hFE, 8);
            cyc(8);
            chk(exp_out(8'hFE, 1'b1, 1'b1), outs);
            force_on = 1'b0;
            cyc(6);
            chk(exp_out(8'hFE, 1'b0, 1'b1), outs);
            sense = 1'b0;
            cyc(6);
            chk(8'h00, {7'h00, flag_n});
            chk(exp_out(8'hFE, 1'b0, 1'b0), outs);
            host.send(8'h5A, 8);
            cyc(8);
            chk(exp_out(8'h5A, 1'b0, 1'b0), outs);
            sense = 1'b1;
            cyc(8);
            chk(8'h01, {7'h00, flag_n});
            chk(exp_out(8'h5A, 1'b0, 1'b1), outs);
            ext_low = 1'b1;
            cyc(6);
            chk(8'h00, outs);
            ext_low = 1'b0;
            cyc(10);
            chk(8'h00, outs);
            host.send(8'hC3, 8);
            cyc(8);
            chk(exp_out(8'hC3, 1'b0, 1'b1), outs);
            // mid-run reset of the whole block
            rst_n = 1'b0;
            cyc(2);
            chk(8'h00, outs);
            chk(8'h01, {7'h00, pin_oe});
            chk(8'h00, {7'h00, pin_out});
            rst_n = 1'b1;
            wait_release;
            chk(8'h00, outs);
            host.send(w, 8);
            cyc(8);
            chk(exp_out(w, 1'b0, 1'b1), outs);
        end
        final_report;
    end
endmodule
bind srocp_top srocp_assertions #(.RESET_DELAY(RESET_DELAY)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .frame_select_n(frame_select_n),
    .first_output_force_on(first_output_force_on), .supply_good(supply_good),
    .brownout_sense_input(brownout_sense_input), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .brownout_flag_n(brownout_flag_n), .driver_outputs(driver_outputs));
